// ### hdl/twi_soft_master_hw_slave.sv
`timescale 1ns/100ps
module twi_soft_master_hw_slave (
	// Core clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Link clock: the serial clock pin level
	input wire logic scl_clk,
	// Pin levels
	input wire logic sda_in,
	input wire logic scl_in,
	// Core side
	input wire twi_pkg::twi_ctrl_s ctrl,
	input wire twi_pkg::twi_access_s acc,
	output twi_pkg::twi_stat_s stat,
	// Pin drive
	output twi_pkg::twi_pins_s pins
);
	import twi_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Link domain: capture of data pin on clock rise
	logic smp_link_r;

	// Runs only while the clock pin moves; value held between edges
	always_ff @(posedge scl_clk or negedge resetn)
	begin
		if (!resetn)
			smp_link_r <= 1'b0;
		else
			smp_link_r <= sda_in;
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronisers into the core domain
	logic sda_m1_r, sda_m2_r, sda_d_r;
	logic scl_m1_r, scl_m2_r, scl_d_r;
	logic smp_m1_r, smp_m2_r;

	// First stages feed only the second stages
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sda_m1_r <= 1'b1;
			sda_m2_r <= 1'b1;
			sda_d_r <= 1'b1;
			scl_m1_r <= 1'b1;
			scl_m2_r <= 1'b1;
			scl_d_r <= 1'b1;
			smp_m1_r <= 1'b0;
			smp_m2_r <= 1'b0;
		end
		else
		begin
			sda_m1_r <= sda_in;
			sda_m2_r <= sda_m1_r;
			sda_d_r <= sda_m2_r;
			scl_m1_r <= scl_in;
			scl_m2_r <= scl_m1_r;
			scl_d_r <= scl_m2_r;
			smp_m1_r <= smp_link_r;
			smp_m2_r <= smp_m1_r;
		end
	end

	// Bus events seen after synchronisation
	wire scl_rise = scl_m2_r & ~scl_d_r;
	wire scl_fall = ~scl_m2_r & scl_d_r;
	wire bus_start = scl_m2_r & scl_d_r & sda_d_r & ~sda_m2_r;
	wire bus_stop = scl_m2_r & scl_d_r & ~sda_d_r & sda_m2_r;

	// Take a capture a cycle after the synced rise, so its copy has surely landed
	logic smp_take_r;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			smp_take_r <= 1'b0;
		else
			smp_take_r <= scl_rise;
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and enable decode
	logic mode_master_r;
	wire if_enable = ~ctrl.shared_port_enable | ctrl.alt_pin_serial_select;
	wire master_act = if_enable & mode_master_r;
	wire slave_act = if_enable & ~mode_master_r;

	// Mode register starts in slave mode
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			mode_master_r <= 1'b0;
		else
			mode_master_r <= ctrl.master_slave_select;
	end

	////////////////////////////////////////////////////////////////////////
	// Slave registers
	twi_state_e state_r, state_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] data_r, data_nxt;
	logic flag_r, flag_nxt;
	logic dir_r, dir_nxt;
	logic gc_r, gc_nxt;
	logic [1:0] code_r, code_nxt;
	logic addressed_r, addressed_nxt;
	logic serviced_r, serviced_nxt;
	logic ack_r, ack_nxt;
	logic smp_r, smp_nxt;

	// Address match ignores the direction bit
	wire [6:0] rx_addr = shift_r[7:1];
	wire addr_own = (rx_addr == ctrl.own_address);
	wire addr_gc = (rx_addr == TWI_GENERAL_CALL);
	wire dat_access = acc.dat_wr | acc.dat_rd;
	wire halt_hit = dat_access & ~flag_r & serviced_r & (state_r != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Slave sequencer and flag handling
	always_comb
	begin
		state_nxt = state_r;
		bitcnt_nxt = bitcnt_r;
		shift_nxt = shift_r;
		data_nxt = data_r;
		dir_nxt = dir_r;
		gc_nxt = gc_r;
		code_nxt = code_r;
		addressed_nxt = addressed_r;
		ack_nxt = ack_r;
		flag_nxt = flag_r;
		serviced_nxt = serviced_r;
		smp_nxt = smp_r;

		// A rise seen while driving leaves the data input bit alone
		if (master_act && !ctrl.sda_output_enable && smp_take_r)
			smp_nxt = smp_m2_r;

		// Core writes land in the data register
		if (acc.dat_wr)
			data_nxt = acc.dat_wdata;

		// Any data register read or write clears the flag
		if (dat_access && flag_r)
		begin
			flag_nxt = 1'b0;
			serviced_nxt = 1'b1;
		end

		// General call bit is sticky until the core clears it
		if (acc.gc_clear)
			gc_nxt = 1'b0;

		case (state_r)
			ST_IDLE: ;
			ST_ADDR:
			begin
				if (scl_rise)
				begin
					shift_nxt = {shift_r[6:0], sda_m2_r};
					bitcnt_nxt = bitcnt_r + 4'h1;
				end
				else if (scl_fall && bitcnt_r == TWI_BYTE_BITS)
				begin
					if (addr_own || addr_gc)
						state_nxt = ST_ADDR_ACK;
					else
						state_nxt = ST_IDLE;
				end
			end
			ST_ADDR_ACK:
			begin
				// Flag raised once the acknowledge clock ends
				if (scl_fall)
				begin
					data_nxt = shift_r;
					dir_nxt = shift_r[TWI_DIR_BIT];
					if (addr_gc)
						gc_nxt = 1'b1;
					code_nxt = addressed_r ? TWI_CODE_RESTART : TWI_CODE_START;
					flag_nxt = 1'b1;
					serviced_nxt = 1'b0;
					addressed_nxt = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				// Clock stays low until the flag is serviced
				if (!flag_r)
				begin
					bitcnt_nxt = 4'h0;
					shift_nxt = data_r;
					state_nxt = dir_r ? ST_TX : ST_RX;
				end
			end
			ST_RX:
			begin
				if (scl_rise)
				begin
					shift_nxt = {shift_r[6:0], sda_m2_r};
					bitcnt_nxt = bitcnt_r + 4'h1;
				end
				else if (scl_fall && bitcnt_r == TWI_BYTE_BITS)
					state_nxt = ST_RX_ACK;
			end
			ST_RX_ACK:
			begin
				if (scl_fall)
				begin
					data_nxt = shift_r;
					code_nxt = TWI_CODE_DATA;
					flag_nxt = 1'b1;
					serviced_nxt = 1'b0;
					state_nxt = ST_WAIT;
				end
			end
			ST_TX:
			begin
				if (scl_fall)
				begin
					shift_nxt = {shift_r[6:0], 1'b1};
					bitcnt_nxt = bitcnt_r + 4'h1;
					if (bitcnt_r == TWI_LAST_BIT)
						state_nxt = ST_TX_ACK;
				end
			end
			ST_TX_ACK:
			begin
				if (scl_rise)
					ack_nxt = ~sda_m2_r;
				else if (scl_fall)
				begin
					if (ack_r)
					begin
						code_nxt = TWI_CODE_DATA;
						flag_nxt = 1'b1;
						serviced_nxt = 1'b0;
						state_nxt = ST_WAIT;
					end
					else
					begin
						addressed_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_HALT: ;
			default: state_nxt = ST_IDLE;
		endcase

		// Bus conditions override the byte sequence, not a halt
		if (state_r != ST_HALT)
		begin
			if (bus_start)
			begin
				bitcnt_nxt = 4'h0;
				state_nxt = ST_ADDR;
			end
			else if (bus_stop)
			begin
				if (addressed_r && ctrl.stop_irq_enable)
				begin
					code_nxt = TWI_CODE_STOP;
					flag_nxt = 1'b1;
					serviced_nxt = 1'b0;
				end
				addressed_nxt = 1'b0;
				state_nxt = ST_IDLE;
			end
		end

		// Second access halts even when a byte step would move on
		if (halt_hit)
			state_nxt = ST_HALT;

		// Interface reset or leaving slave mode forces idle
		if (ctrl.interface_reset || !slave_act)
		begin
			state_nxt = ST_IDLE;
			addressed_nxt = 1'b0;
			flag_nxt = 1'b0;
			serviced_nxt = 1'b0;
		end
	end

	// Slave state flip-flops
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			bitcnt_r <= 4'h0;
			shift_r <= TWI_DATA_RST;
			data_r <= TWI_DATA_RST;
			flag_r <= 1'b0;
			dir_r <= 1'b0;
			gc_r <= 1'b0;
			code_r <= TWI_CODE_START;
			addressed_r <= 1'b0;
			serviced_r <= 1'b0;
			ack_r <= 1'b0;
			smp_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bitcnt_r <= bitcnt_nxt;
			shift_r <= shift_nxt;
			data_r <= data_nxt;
			flag_r <= flag_nxt;
			dir_r <= dir_nxt;
			gc_r <= gc_nxt;
			code_r <= code_nxt;
			addressed_r <= addressed_nxt;
			serviced_r <= serviced_nxt;
			ack_r <= ack_nxt;
			smp_r <= smp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive selection
	// Slave pulls low only: acknowledge, zero data bits, stretch
	wire slave_pull_sda = (state_r == ST_ADDR_ACK) | (state_r == ST_RX_ACK) |
		((state_r == ST_TX) & ~shift_r[7]);
	wire slave_pull_scl = (state_r == ST_WAIT);
	wire sda_oe_sel = master_act ? ctrl.sda_output_enable : (slave_act & slave_pull_sda);
	wire sda_out_sel = master_act & ctrl.sda_output_value;
	wire scl_oe_sel = master_act | (slave_act & slave_pull_scl);
	wire scl_out_sel = master_act & ctrl.scl_output_value;

	// Request needs both enables; vector rides along
	wire irq_sel = flag_r & ctrl.peripheral_irq_enable & ctrl.global_irq_enable;

	twi_pins_s pins_nxt;
	twi_stat_s stat_nxt;
	assign pins_nxt = '{sda_out: sda_out_sel, sda_oe: sda_oe_sel,
		scl_out: scl_out_sel, scl_oe: scl_oe_sel};
	assign stat_nxt = '{sda_input_sample: smp_nxt, serial_interrupt_flag: flag_nxt,
		transfer_direction: dir_nxt, general_call_status: gc_nxt,
		irq_source_code_hi: code_nxt[1], irq_source_code_lo: code_nxt[0],
		slave_data: data_nxt, halted: (state_nxt == ST_HALT), irq_req: irq_sel,
		irq_vector: TWI_VECTOR_ADDR};

	////////////////////////////////////////////////////////////////////////
	// Output flip-flops; pins released during reset
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pins <= '0;
			stat <= '{irq_vector: TWI_VECTOR_ADDR, slave_data: TWI_DATA_RST, default: 1'b0};
		end
		else
		begin
			pins <= pins_nxt;
			stat <= stat_nxt;
		end
	end

endmodule

// ### hdl/twi_pkg.sv
// Overview of operation
// - Mode bit set selects master, clear selects slave
// - Master drives data pin from data bit
// - Master clock pin always driven from clock bit
// - Output enable clear releases data pin
// - Data input bit latched on clock rise in master mode with output enable clear
// - Reset leaves the interface in slave mode
// - Enabled by port enable clear or alt select
// - Own address compared, data register holds bytes
// - Start, matching address, direction bit set flag
// - Interrupt request needs both enable bits set
// - Data register access clears the interrupt flag
// - Second access per interrupt halts until reset
// - Fixed handler address presented per complete byte
// - First byte shows address and direction bit
// - Direction bit chooses slave transmit or receive
// - Clock held low until a byte flag is cleared
// - Flag only for bytes followed by acknowledge
// - Flags continue until stop or interface reset
// - Stop or not-acknowledge returns slave to idle
// - Interface reset forces slave back to idle
// - Source code 00/01/10/11 names interrupt cause
// - Stop interrupt when enabled after valid start
// - General call address sets sticky status bit
package twi_pkg;

	// Interrupt source codes
	localparam logic [1:0] TWI_CODE_START = 2'h0;
	localparam logic [1:0] TWI_CODE_RESTART = 2'h1;
	localparam logic [1:0] TWI_CODE_DATA = 2'h2;
	localparam logic [1:0] TWI_CODE_STOP = 2'h3;

	// Fixed handler address presented with a request
	localparam logic [15:0] TWI_VECTOR_ADDR = 16'h003b;

	// Address byte layout and reserved address
	localparam logic [6:0] TWI_GENERAL_CALL = 7'h00;
	localparam int TWI_DIR_BIT = 0;
	localparam logic [3:0] TWI_BYTE_BITS = 4'h8;
	localparam logic [3:0] TWI_LAST_BIT = 4'h7;
	localparam logic [7:0] TWI_DATA_RST = 8'h00;

	// Controls from the core, same clock as the block
	typedef struct packed {
		logic master_slave_select;
		logic sda_output_enable;
		logic sda_output_value;
		logic scl_output_value;
		logic shared_port_enable;
		logic alt_pin_serial_select;
		logic interface_reset;
		logic stop_irq_enable;
		logic peripheral_irq_enable;
		logic global_irq_enable;
		logic [6:0] own_address;
	} twi_ctrl_s;

	// Core access to the slave data register
	typedef struct packed {
		logic dat_wr;
		logic dat_rd;
		logic [7:0] dat_wdata;
		logic gc_clear;
	} twi_access_s;

	// State visible to the core
	typedef struct packed {
		logic sda_input_sample;
		logic serial_interrupt_flag;
		logic transfer_direction;
		logic general_call_status;
		logic irq_source_code_hi;
		logic irq_source_code_lo;
		logic [7:0] slave_data;
		logic halted;
		logic irq_req;
		logic [15:0] irq_vector;
	} twi_stat_s;

	// Pin drive, enable high while driving
	typedef struct packed {
		logic sda_out;
		logic sda_oe;
		logic scl_out;
		logic scl_oe;
	} twi_pins_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WAIT,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_HALT
	} twi_state_e;

endpackage

// ### sim/twi_props.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Port checks; pin checks allow three edges for the flops
module twi_props (
	// Clocks and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl_clk,
	// Pin levels
	input wire logic sda_in,
	input wire logic scl_in,
	// Core side and pin drive
	input wire twi_pkg::twi_ctrl_s ctrl,
	input wire twi_pkg::twi_access_s acc,
	input wire twi_pkg::twi_stat_s stat,
	input wire twi_pkg::twi_pins_s pins
);
	import twi_pkg::*;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// Mode decodes
	wire en = !ctrl.shared_port_enable || ctrl.alt_pin_serial_select;
	wire em = en && ctrl.master_slave_select;
	wire es = en && !ctrl.master_slave_select && !ctrl.interface_reset;
	wire [1:0] code = {stat.irq_source_code_hi, stat.irq_source_code_lo};
	sequence s_clr;
		stat.serial_interrupt_flag && (acc.dat_rd || acc.dat_wr);
	endsequence
	sequence s_wait;
		(es && stat.serial_interrupt_flag && code != TWI_CODE_STOP)[*3];
	endsequence
	property p_irq;
		(!ctrl.peripheral_irq_enable || !ctrl.global_irq_enable)[*2] |-> !stat.irq_req;
	endproperty
	a_irq: assert property (p_irq) else $error("request without enables");
	property p_scl;
		(em && ctrl.scl_output_value)[*3] |-> pins.scl_oe && pins.scl_out;
	endproperty
	a_scl: assert property (p_scl) else $error("clock pin not driven high");
	property p_sda;
		(em && ctrl.sda_output_enable && !ctrl.sda_output_value)[*3] |-> pins.sda_oe && !pins.sda_out;
	endproperty
	a_sda: assert property (p_sda) else $error("data pin not driven low");
	property p_off;
		(em && !ctrl.sda_output_enable)[*3] |-> !pins.sda_oe && pins.scl_oe;
	endproperty
	a_off: assert property (p_off) else $error("data driver not off");
	property p_dis;
		(!en)[*3] |-> !pins.sda_oe && !pins.scl_oe;
	endproperty
	a_dis: assert property (p_dis) else $error("disabled block drives");
	property p_clr;
		s_clr |-> ##[1:2] !stat.serial_interrupt_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_hold;
		s_wait |-> pins.scl_oe && !pins.scl_out;
	endproperty
	a_hold: assert property (p_hold) else $error("clock not held low");
	property p_halt;
		(es && stat.halted)[*2] |=> stat.halted && !pins.scl_oe && !pins.sda_oe;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not kept");
endmodule

bind twi_soft_master_hw_slave twi_props u_props (.mclk(mclk), .resetn(resetn),
	.scl_clk(scl_clk), .sda_in(sda_in), .scl_in(scl_in), .ctrl(ctrl), .acc(acc),
	.stat(stat), .pins(pins));

// ### sim/twi_bus_model.sv
`timescale 1ns/100ps
// Far-side master, open drain; clock runs only within frames
module twi_bus_model (
	// Wire levels
	input wire logic scl,
	input wire logic sda,
	// Pull-low drives, stretch timeout
	output logic scl_low,
	output logic sda_low,
	output logic stuck
);
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 1'b0;
	end
	// Release clock; bounded wait, a slave may stretch
	task automatic hi();
		int n;
		scl_low = 1'b0;
		for (n = 0; n < 500 && !scl; n++)
			#10;
		stuck = stuck || n == 500;
		#63;
	endtask
	task automatic set_sda(input logic b);
		sda_low = !b;
	endtask
	// Data set while low, sampled at end of high
	task automatic xbit(input logic b, output logic r);
		sda_low = !b;
		#31;
		hi();
		r = sda;
		scl_low = 1'b1;
		#31;
	endtask
	// Byte MSB first, then acknowledge slot
	task automatic xbyte(input logic [7:0] v, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--)
			xbit(v[i], r[i]);
		xbit(a, k);
	endtask
	// Start or repeated start
	task automatic start();
		sda_low = 1'b0;
		#31;
		hi();
		sda_low = 1'b1;
		#31;
		scl_low = 1'b1;
		#31;
	endtask
	// Stop, then idle with both lines released
	task automatic stop();
		sda_low = 1'b1;
		#31;
		hi();
		sda_low = 1'b0;
		#63;
	endtask
endmodule

// ### sim/tb_i2c_soft_master_hw_slave.sv
`timescale 1ns/100ps
// Random bench with fixed seed
module tb_i2c_soft_master_hw_slave;
	import twi_pkg::*;
	logic mclk;
	logic resetn;
	twi_ctrl_s ctrl;
	twi_access_s acc;
	twi_stat_s stat;
	twi_pins_s pins;
	wire scl_low;
	wire sda_low;
	wire stuck;
	int fail_count;
	int checks_done;
	int seed;
	logic [7:0] r8;
	logic [7:0] d;
	logic [6:0] own;
	logic k;
	logic ps;
	logic es;
	// Wired-and lines with pull-ups
	wire scl = !scl_low && !(pins.scl_oe && !pins.scl_out);
	wire sda = !sda_low && !(pins.sda_oe && !pins.sda_out);
	wire [1:0] code = {stat.irq_source_code_hi, stat.irq_source_code_lo};
	twi_soft_master_hw_slave DUT (.mclk(mclk), .resetn(resetn), .scl_clk(scl), .sda_in(sda),
		.scl_in(scl), .ctrl(ctrl), .acc(acc), .stat(stat), .pins(pins));
	twi_bus_model bus (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .stuck(stuck));
	////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = !mclk;
	end
	// Sample bit moves only on a rise with driver off
	function automatic logic nxt_smp(input logic rise, input logic oe, input logic lvl, input logic o);
		return (rise && !oe) ? lvl : o;
	endfunction
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_flag();
		int n;
		for (n = 0; n < 400 && stat.serial_interrupt_flag !== 1'b1; n++)
		begin
			@(posedge mclk);
			#1;
		end
		// Pin drive follows the state one cycle after the flag
		@(posedge mclk);
		#1;
		if (n == 400)
		begin
			fail_count++;
			end_of_test();
		end
	endtask
	// One data register access pulse
	task automatic core(input logic rd, input logic [7:0] v);
		@(posedge mclk);
		acc.dat_rd <= rd;
		acc.dat_wr <= !rd;
		acc.dat_wdata <= v;
		@(posedge mclk);
		acc.dat_rd <= 1'b0;
		acc.dat_wr <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic addr(input logic [6:0] a, input logic rw, input logic [1:0] c);
		bus.start();
		bus.xbyte({a, rw}, 1'b1, r8, k);
		wait_flag();
		chk("addr", {k, code, stat.transfer_direction, stat.slave_data, pins.scl_oe, pins.scl_out},
			{1'b0, c, rw, a, rw, 2'b10});
	endtask
	////////////////////////////////////////
	initial
	begin
		seed = 30;
		fail_count = 0;
		checks_done = 0;
		ps = 1'b0;
		es = 1'b0;
		resetn = 1'b0;
		ctrl = '0;
		acc = '0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk("reset", {pins.sda_oe, pins.scl_oe}, 2'b00);
		chk("vector", stat.irq_vector, TWI_VECTOR_ADDR);
		// Software master: random pin settings
		for (int i = 0; i < 16; i++)
		begin
			r8 = $random(seed);
			@(posedge mclk);
			ctrl.master_slave_select <= 1'b1;
			ctrl.sda_output_enable <= r8[0];
			ctrl.sda_output_value <= r8[1];
			bus.set_sda(r8[3]);
			repeat (4) @(posedge mclk);
			ctrl.scl_output_value <= r8[2];
			repeat (8) @(posedge mclk);
			#1;
			es = nxt_smp(r8[2] && !ps, r8[0], r8[3], es);
			ps = r8[2];
			chk("pins", pins, {12'h000, r8[1:0], r8[2], 1'b1});
			chk("sample", stat.sda_input_sample, es);
		end
		// Hardware slave: receive bytes, then a second access halts
		r8 = $random(seed);
		own = {1'b1, r8[5:0]};
		@(posedge mclk);
		ctrl.master_slave_select <= 1'b0;
		ctrl.own_address <= own;
		ctrl.peripheral_irq_enable <= 1'b1;
		ctrl.global_irq_enable <= 1'b1;
		bus.set_sda(1'b1);
		repeat (4) @(posedge mclk);
		addr(own, 1'b0, TWI_CODE_START);
		chk("irq", stat.irq_req, 1);
		core(1'b1, 8'h00);
		chk("clear", {stat.serial_interrupt_flag, stat.irq_req}, 0);
		for (int i = 0; i < 3; i++)
		begin
			d = $random(seed);
			bus.xbyte(d, 1'b1, r8, k);
			wait_flag();
			chk("data", {k, code, stat.slave_data}, {1'b0, TWI_CODE_DATA, d});
			core(1'b1, 8'h00);
		end
		core(1'b1, 8'h00);
		chk("halt", {stat.halted, pins.scl_oe, pins.sda_oe}, 3'b100);
		bus.stop();
		@(posedge mclk);
		ctrl.interface_reset <= 1'b1;
		repeat (4) @(posedge mclk);
		ctrl.interface_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("unhalt", stat.halted, 0);
		// Repeated start into transmit, master ends with no acknowledge
		addr(own, 1'b0, TWI_CODE_START);
		core(1'b1, 8'h00);
		addr(own, 1'b1, TWI_CODE_RESTART);
		d = $random(seed);
		core(1'b0, d);
		bus.xbyte(8'hff, 1'b1, r8, k);
		repeat (40) @(posedge mclk);
		#1;
		chk("tx", {r8, stat.serial_interrupt_flag, pins.scl_oe}, {d, 2'b00});
		bus.stop();
		// Stop event, foreign address, general call
		@(posedge mclk);
		ctrl.stop_irq_enable <= 1'b1;
		addr(own, 1'b0, TWI_CODE_START);
		core(1'b1, 8'h00);
		bus.stop();
		wait_flag();
		chk("stop", {code, pins.scl_oe}, {TWI_CODE_STOP, 1'b0});
		core(1'b1, 8'h00);
		bus.start();
		bus.xbyte({own ^ 7'h01, 1'b0}, 1'b1, r8, k);
		bus.stop();
		repeat (40) @(posedge mclk);
		#1;
		chk("foreign", {k, stat.serial_interrupt_flag}, 2'b10);
		@(posedge mclk);
		ctrl.stop_irq_enable <= 1'b0;
		addr(TWI_GENERAL_CALL, 1'b0, TWI_CODE_START);
		core(1'b1, 8'h00);
		bus.stop();
		chk("gc", stat.general_call_status, 1);
		@(posedge mclk);
		acc.gc_clear <= 1'b1;
		@(posedge mclk);
		acc.gc_clear <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("gc clr", stat.general_call_status, 0);
		// Disabled, then enabled by the alternate select
		@(posedge mclk);
		ctrl.shared_port_enable <= 1'b1;
		bus.start();
		bus.xbyte({own, 1'b0}, 1'b1, r8, k);
		bus.stop();
		chk("off", k, 1);
		@(posedge mclk);
		ctrl.alt_pin_serial_select <= 1'b1;
		addr(own, 1'b0, TWI_CODE_START);
		core(1'b1, 8'h00);
		bus.stop();
		chk("stretch", stuck, 0);
		end_of_test();
	end
endmodule
